// *** rtl/hseq_pkg.sv ***
// Constants, types and step table for the homing sequencer
`default_nettype none
package hseq_pkg;

  // ==========================================================================
  // Mode selection
  localparam logic [5:0] MODE_FIRST = 6'h18;
  localparam logic [5:0] MODE_LAST  = 6'h1B;
  localparam logic [1:0] MODE_NEG   = 2'h3;

  // ==========================================================================
  // Branches and directions
  localparam logic [1:0] BR_ACT   = 2'h0;
  localparam logic [1:0] BR_INACT = 2'h1;
  localparam logic [1:0] BR_REV   = 2'h2;
  localparam logic       DIR_POS  = 1'h1;
  localparam logic       DIR_NEG  = 1'h0;
  localparam logic [1:0] IDX_ZERO = 2'h0;
  localparam logic [1:0] IDX_ONE  = 2'h1;

  // ==========================================================================
  // Sequencer state
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RUN   = 3'b001,
    ST_STOP  = 3'b010,
    ST_DONE  = 3'b011,
    ST_ALARM = 3'b100
  } hseq_state_e;

  typedef struct packed {
    logic valid;
    logic dir;
    logic high;
    logic rise;
  } hseq_step_s;

  // ==========================================================================
  // One motion step: direction, speed and the switch edge that ends it
  function automatic hseq_step_s hseq_mk(input logic dir, input logic high,
                                         input logic rise);
    hseq_step_s s;
    s.valid = 1'b1;
    s.dir   = dir;
    s.high  = high;
    s.rise  = rise;
    return s;
  endfunction

  localparam logic H = 1'b1;
  localparam logic L = 1'b0;
  localparam logic R = 1'b1;
  localparam logic F = 1'b0;

  // Index is {mode-24, branch, step}; missing entries end the program
  function automatic hseq_step_s hseq_step_f(input logic [1:0] m,
                                             input logic [1:0] br,
                                             input logic [1:0] idx);
    hseq_step_s s;
    s = '0;
    case ({m, br, idx})
      6'h00: s = hseq_mk(DIR_NEG, H, F);
      6'h01: s = hseq_mk(DIR_POS, L, R);
      6'h04: s = hseq_mk(DIR_POS, H, R);
      6'h05: s = hseq_mk(DIR_NEG, H, F);
      6'h06: s = hseq_mk(DIR_POS, L, R);
      6'h08: s = hseq_mk(DIR_NEG, H, F);
      6'h09: s = hseq_mk(DIR_POS, L, R);
      6'h10: s = hseq_mk(DIR_POS, H, F);
      6'h11: s = hseq_mk(DIR_NEG, L, R);
      6'h14: s = hseq_mk(DIR_POS, H, F);
      6'h15: s = hseq_mk(DIR_NEG, L, R);
      6'h18: s = hseq_mk(DIR_NEG, H, R);
      6'h19: s = hseq_mk(DIR_POS, H, F);
      6'h1A: s = hseq_mk(DIR_NEG, L, R);
      6'h20, 6'h24, 6'h30, 6'h38: s = hseq_mk(DIR_POS, H, F);
      6'h21, 6'h25, 6'h31, 6'h39: s = hseq_mk(DIR_NEG, H, R);
      6'h22, 6'h26, 6'h32, 6'h3A: s = hseq_mk(DIR_POS, L, F);
      6'h28: s = hseq_mk(DIR_NEG, H, R);
      6'h29: s = hseq_mk(DIR_POS, L, F);
      6'h34: s = hseq_mk(DIR_NEG, H, R);
      6'h35: s = hseq_mk(DIR_POS, L, F);
      default: s = '0;
    endcase
    return s;
  endfunction

endpackage
`default_nettype wire

// *** rtl/hseq_sw_cond.sv ***
// Switch sampler and edge detector for home and limit inputs
`timescale 1ns/1ns
`default_nettype none
module hseq_sw_cond (
  input  wire logic clk_sys_in,
  input  wire logic rstn_in,
  input  wire logic home_switch_in,
  input  wire logic positive_limit_in,
  input  wire logic negative_limit_in,
  hseq_sw_if.cond   sw
);

  // ==========================================================================
  // Sample and previous sample of each switch
  logic [2:0] smp;
  logic [2:0] prv;
  logic       primed;
  logic [2:0] next_smp;
  logic [2:0] next_prv;
  logic       next_primed;

  always_comb begin
    next_smp    = {negative_limit_in, positive_limit_in, home_switch_in};
    // First sample after reset fills both stages, so no false edge
    next_prv    = primed ? smp : next_smp;
    next_primed = 1'b1;
  end

  // A switch already on at release is seen as a level, never an edge
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      smp    <= 3'h0;
      prv    <= 3'h0;
      primed <= 1'b0;
    end else begin
      smp    <= next_smp;
      prv    <= next_prv;
      primed <= next_primed;
    end
  end

  assign sw.home_lvl  = smp[0];
  assign sw.home_rise = smp[0] & ~prv[0]; // RL15
  assign sw.home_fall = ~smp[0] & prv[0]; // RL15
  assign sw.pos_rise  = smp[1] & ~prv[1];
  assign sw.neg_rise  = smp[2] & ~prv[2];

endmodule
`default_nettype wire

// *** rtl/hseq_sw_if.sv ***
// Conditioned switch levels and edges shared inside the sequencer
`timescale 1ns/1ns
`default_nettype none
interface hseq_sw_if;
  logic home_lvl;
  logic home_rise;
  logic home_fall;
  logic pos_rise;
  logic neg_rise;

  modport cond (output home_lvl, home_rise, home_fall, pos_rise, neg_rise);
  modport seq  (input  home_lvl, home_rise, home_fall, pos_rise, neg_rise);
endinterface
`default_nettype wire

// *** rtl/hseq_top.sv ***
// Homing sequencer for home-search modes 24 to 27
// Function
// RL1 - Mode 24 inactive on the positive side searches positive fast, reverses at the positive limit, stops at the switch fall, then approaches positive slowly to its rise.
// RL2 - Mode 24 inactive on the negative side runs positive fast to the rise, retreats fast past the fall, then runs positive slowly to the rise.
// RL3 - Mode 24 active at start runs negative fast to the fall, then positive slowly to the rise.
// RL4 - Modes 24 to 26 reverse on the first positive limit while moving positive and abort with alarm on the negative limit or a second positive limit.
// RL5 - Mode 25 inactive on the positive side reverses at the positive limit, runs negative fast to the rise and retreats fast past the fall.
// RL6 - Mode 25 then runs negative slowly to the rise, and inactive on the negative side runs positive fast to the fall then negative slowly to the rise.
// RL7 - Mode 25 active at start runs positive fast to the fall, then negative slowly to the rise.
// RL8 - Mode 26 inactive on the positive side reverses at the positive limit, runs negative fast to the rise, then positive slowly to the fall.
// RL9 - Mode 26 inactive on the negative side runs positive fast to the fall, returns fast to the rise, then positive slowly to the fall.
// RL10 - Modes 26 and 27 active at start run positive fast to the fall, return fast to the rise, then positive slowly to the fall.
// RL11 - Mode 27 inactive on the positive side runs negative fast to the rise, then positive slowly to the fall.
// RL12 - Mode 27 inactive on the negative side reverses at the negative limit, runs positive fast to the fall, returns to the rise, then positive slowly to the fall.
// RL13 - Mode 27 reverses on the first negative limit while moving negative and aborts with alarm on the positive limit or a second negative limit.
// RL14 - The position where the last slow stop reaches zero velocity is latched as home.
// RL15 - The switch level at start picks the branch and edges are changes between successive samples.
// RL16 - No new direction or speed command is given until the profile reports zero velocity after a stop; a start in the alarm state runs at once.
`timescale 1ns/1ns
`default_nettype none
module hseq_top #(
  parameter int POS_W = 32
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rstn_in,
  input  wire logic             start_in,
  input  wire logic [5:0]       mode_in,
  input  wire logic             home_switch_in,
  input  wire logic             positive_limit_in,
  input  wire logic             negative_limit_in,
  input  wire logic             zero_vel_in,
  input  wire logic [POS_W-1:0] pos_in,
  output logic                  run_out,
  output logic                  dir_out,
  output logic                  speed_high_out,
  output logic                  stop_out,
  output logic                  busy_out,
  output logic                  done_out,
  output logic                  alarm_out,
  output logic                  home_valid_out,
  output logic [POS_W-1:0]      home_pos_out
);

  // ==========================================================================
  // Switch conditioning
  hseq_sw_if sw ();

  hseq_sw_cond u_cond (
    .clk_sys_in        (clk_sys_in),
    .rstn_in           (rstn_in),
    .home_switch_in    (home_switch_in),
    .positive_limit_in (positive_limit_in),
    .negative_limit_in (negative_limit_in),
    .sw                (sw)
  );

  // ==========================================================================
  // Sequencer state
  hseq_pkg::hseq_state_e state;
  hseq_pkg::hseq_state_e next_state;
  logic [1:0]            mode;
  logic [1:0]            next_mode;
  logic [1:0]            br;
  logic [1:0]            next_br;
  logic [1:0]            idx;
  logic [1:0]            next_idx;
  logic                  rev_used;
  logic                  next_rev_used;
  logic                  pend_rev;
  logic                  next_pend_rev;
  logic                  next_run;
  logic                  next_dir;
  logic                  next_high;
  logic                  next_stop;
  logic                  next_busy;
  logic                  next_done;
  logic                  next_alarm;
  logic                  next_home_valid;
  logic [POS_W-1:0]      next_home_pos;

  hseq_pkg::hseq_step_s  cur;
  hseq_pkg::hseq_step_s  nxt;
  hseq_pkg::hseq_step_s  nstep;
  logic                  neg_mode;
  logic                  hit;
  logic                  lim_rev;
  logic                  lim_oth;
  logic                  rev_ok;
  logic                  abort;
  logic                  moving;
  logic                  start_ok;

  assign cur      = hseq_pkg::hseq_step_f(mode, br, idx);
  assign nxt      = hseq_pkg::hseq_step_f(mode, br,
                                          2'(idx + hseq_pkg::IDX_ONE));
  assign neg_mode = (mode == hseq_pkg::MODE_NEG);
  assign hit      = cur.rise ? sw.home_rise : sw.home_fall;
  assign lim_rev  = neg_mode ? sw.neg_rise : sw.pos_rise; // RL4 RL13
  assign lim_oth  = neg_mode ? sw.pos_rise : sw.neg_rise; // RL4 RL13
  assign moving   = (state == hseq_pkg::ST_RUN) ||
                    (state == hseq_pkg::ST_STOP);
  // Reversal only once, and only while heading toward that limit
  assign rev_ok   = (state == hseq_pkg::ST_RUN) && lim_rev && !rev_used &&
                    (cur.dir == (neg_mode ? hseq_pkg::DIR_NEG
                                          : hseq_pkg::DIR_POS)); // RL4 RL13
  assign abort    = moving && (lim_oth || (lim_rev && !rev_ok)); // RL4 RL13
  assign start_ok = (mode_in >= hseq_pkg::MODE_FIRST) &&
                    (mode_in <= hseq_pkg::MODE_LAST);

  always_comb begin
    next_state      = state;
    next_mode       = mode;
    next_br         = br;
    next_idx        = idx;
    next_rev_used   = rev_used;
    next_pend_rev   = pend_rev;
    next_home_valid = home_valid_out;
    next_home_pos   = home_pos_out;
    next_alarm      = alarm_out;
    case (state)
      hseq_pkg::ST_IDLE, hseq_pkg::ST_DONE, hseq_pkg::ST_ALARM: begin
        if (start_in) begin
          next_home_valid = 1'b0;
          next_rev_used   = 1'b0;
          next_pend_rev   = 1'b0;
          next_idx        = hseq_pkg::IDX_ZERO;
          if (start_ok) begin
            next_mode  = 2'(mode_in - hseq_pkg::MODE_FIRST);
            next_br    = sw.home_lvl ? hseq_pkg::BR_ACT
                                     : hseq_pkg::BR_INACT; // RL15
            next_alarm = 1'b0;
            next_state = hseq_pkg::ST_RUN;
          end else begin
            // Unsupported mode is refused with the alarm
            next_alarm = 1'b1;
            next_state = hseq_pkg::ST_ALARM;
          end
        end
      end
      hseq_pkg::ST_RUN: begin
        if (abort) begin
          next_alarm = 1'b1;
          next_state = hseq_pkg::ST_ALARM;
        end else if (rev_ok) begin
          next_pend_rev = 1'b1; // RL4 RL13
          next_state    = hseq_pkg::ST_STOP;
        end else if (hit) begin
          next_state = hseq_pkg::ST_STOP; // RL1 RL5 RL8 RL12
        end
      end
      hseq_pkg::ST_STOP: begin
        if (abort) begin
          next_alarm = 1'b1;
          next_state = hseq_pkg::ST_ALARM;
        end else if (zero_vel_in) begin // RL16
          if (pend_rev) begin
            next_pend_rev = 1'b0;
            next_rev_used = 1'b1;
            next_br       = hseq_pkg::BR_REV;
            next_idx      = hseq_pkg::IDX_ZERO;
            next_state    = hseq_pkg::ST_RUN;
          end else if (!nxt.valid) begin
            next_home_pos   = pos_in; // RL14
            next_home_valid = 1'b1;   // RL14
            next_state      = hseq_pkg::ST_DONE;
          end else begin
            next_idx   = 2'(idx + hseq_pkg::IDX_ONE); // RL2 RL6 RL9 RL10
            next_state = hseq_pkg::ST_RUN;
          end
        end
      end
      default: begin
        next_state = hseq_pkg::ST_IDLE;
      end
    endcase
    // Command outputs follow the state being entered
    nstep     = hseq_pkg::hseq_step_f(next_mode, next_br, next_idx);
    next_run  = (next_state == hseq_pkg::ST_RUN);
    next_stop = (next_state == hseq_pkg::ST_STOP) ||
                (next_state == hseq_pkg::ST_ALARM); // RL16
    next_busy = next_run || (next_state == hseq_pkg::ST_STOP);
    next_done = (next_state == hseq_pkg::ST_DONE);
    // Direction and speed hold through the stop so the profile sees them
    next_dir  = next_run ? nstep.dir  : dir_out; // RL3 RL7 RL11
    next_high = next_run ? nstep.high : speed_high_out;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      state          <= hseq_pkg::ST_IDLE;
      mode           <= 2'h0;
      br             <= hseq_pkg::BR_ACT;
      idx            <= hseq_pkg::IDX_ZERO;
      rev_used       <= 1'b0;
      pend_rev       <= 1'b0;
      run_out        <= 1'b0;
      dir_out        <= hseq_pkg::DIR_POS;
      speed_high_out <= 1'b0;
      stop_out       <= 1'b0;
      busy_out       <= 1'b0;
      done_out       <= 1'b0;
      alarm_out      <= 1'b0;
      home_valid_out <= 1'b0;
      home_pos_out   <= '0;
    end else begin
      state          <= next_state;
      mode           <= next_mode;
      br             <= next_br;
      idx            <= next_idx;
      rev_used       <= next_rev_used;
      pend_rev       <= next_pend_rev;
      run_out        <= next_run;
      dir_out        <= next_dir;
      speed_high_out <= next_high;
      stop_out       <= next_stop;
      busy_out       <= next_busy;
      done_out       <= next_done;
      alarm_out      <= next_alarm;
      home_valid_out <= next_home_valid;
      home_pos_out   <= next_home_pos;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  sequence s_start(logic [5:0] m, logic lvl);
    !moving && start_in && mode_in == m && sw.home_lvl == lvl;
  endsequence

  sequence s_rev_hit;
    state == hseq_pkg::ST_RUN && rev_ok && !lim_oth;
  endsequence

  a_neg_limit_abort: assert property ( // RL4
    moving && !neg_mode && sw.neg_rise |=> alarm_out && stop_out && !run_out)
    else $error("negative limit did not abort");

  a_pos_limit_abort: assert property ( // RL13
    moving && neg_mode && sw.pos_rise |=> alarm_out && stop_out)
    else $error("positive limit did not abort in mode 27");

  a_first_reverse: assert property ( // RL4
    s_rev_hit |=> stop_out && !alarm_out ##0
    (stop_out && !run_out) [*1] ##0 rev_used == 1'b0)
    else $error("first limit did not stop for reversal");

  a_hold_until_zero: assert property ( // RL16
    state == hseq_pkg::ST_STOP && !zero_vel_in && !abort
    |=> !run_out && stop_out)
    else $error("new command issued before zero velocity");

  a_home_latch_pos: assert property ( // RL14
    $rose(home_valid_out) |-> home_pos_out == $past(pos_in) &&
    done_out && !speed_high_out)
    else $error("home position not latched at final slow stop");

  a_mode24_active: assert property ( // RL3
    s_start(6'h18, 1'b1) |=> run_out && !dir_out && speed_high_out)
    else $error("mode 24 active start not negative fast");

  a_mode25_active: assert property ( // RL7
    s_start(6'h19, 1'b1) |=> run_out && dir_out && speed_high_out)
    else $error("mode 25 active start not positive fast");

  a_mode27_inactive: assert property ( // RL11
    s_start(6'h1B, 1'b0) |=> run_out && !dir_out ##0
    (!done_out) [*2])
    else $error("mode 27 inactive start not negative");

  a_edge_stops: assert property ( // RL1
    state == hseq_pkg::ST_RUN && hit && !lim_rev && !lim_oth
    |=> stop_out && !run_out ##1 (!run_out || $past(zero_vel_in)))
    else $error("switch edge did not stop the axis");

  sequence s_rev_resume;
    state == hseq_pkg::ST_STOP && pend_rev && zero_vel_in && !abort;
  endsequence

  a_reverse_resume: assert property ( // RL4
    s_rev_resume |=> run_out && speed_high_out && rev_used &&
    dir_out == (neg_mode ? hseq_pkg::DIR_POS : hseq_pkg::DIR_NEG))
    else $error("reversed branch did not start away from the limit");

  a_second_limit: assert property ( // RL13
    moving && rev_used && lim_rev |=> alarm_out && stop_out && !run_out)
    else $error("second limit did not abort");

  a_start_accept: assert property ( // RL15
    !moving && start_in && start_ok |=> busy_out && run_out &&
    !alarm_out && !home_valid_out)
    else $error("valid start not accepted");

  a_bad_mode_alarm: assert property ( // RL15
    !moving && start_in && !start_ok |=> alarm_out && stop_out && !busy_out)
    else $error("unsupported mode not refused");

  a_final_stop: assert property ( // RL14
    state == hseq_pkg::ST_STOP && zero_vel_in && !pend_rev && !nxt.valid &&
    !abort |=> done_out && home_valid_out && !stop_out && !busy_out)
    else $error("final stop did not complete homing");

endmodule
`default_nettype wire

// *** testbench/hseq_axis.sv ***
// Behavioural axis with home switch, travel limits and a stop profile
`timescale 1ns/1ns
`default_nettype none
module hseq_axis #(
  parameter int HOME_LO = 400,
  parameter int HOME_HI = 600,
  parameter int PLIM    = 1000,
  parameter int NLIM    = 100
) (
  input  wire logic        clk_sys_in,
  input  wire logic        load_in,
  input  wire logic [31:0] load_pos_in,
  input  wire logic [3:0]  decel_in,
  input  wire logic        pl_glitch_in,
  input  wire logic        nl_glitch_in,
  input  wire logic        run_in,
  input  wire logic        dir_in,
  input  wire logic        speed_high_in,
  output logic             home_switch_out,
  output logic             positive_limit_out,
  output logic             negative_limit_out,
  output logic             zero_vel_out,
  output logic [31:0]      pos_out,
  output logic [3:0]       seg_cnt_out,
  output logic [15:0]      seg_log_out,
  output logic [7:0]       viol_out
);
  // ==========================================================================
  // Travel and switches
  int         pos = 0;
  logic [3:0] slow_cnt;
  logic       run_d;
  logic       zv_d;

  assign pos_out            = 32'(pos);
  assign home_switch_out    = (pos >= HOME_LO) && (pos <= HOME_HI);
  assign positive_limit_out = (pos >= PLIM) || pl_glitch_in;
  assign negative_limit_out = (pos <= NLIM) || nl_glitch_in;
  // Slow profile keeps zero velocity low for decel_in cycles after run drops
  assign zero_vel_out       = !run_in && (slow_cnt == 4'h0);

  // ==========================================================================
  // Motion, segment log and restart-before-zero-velocity watch
  always @(posedge clk_sys_in) begin
    run_d <= run_in;
    zv_d  <= zero_vel_out;
    if (load_in) begin
      pos         <= int'(load_pos_in);
      slow_cnt    <= 4'h0;
      seg_cnt_out <= 4'h0;
      seg_log_out <= 16'h0000;
      viol_out    <= 8'h00;
    end else begin
      if (run_in) begin
        pos      <= dir_in ? pos + (speed_high_in ? 4 : 1)
                           : pos - (speed_high_in ? 4 : 1);
        slow_cnt <= decel_in;
      end else if (slow_cnt != 4'h0) begin
        slow_cnt <= slow_cnt - 4'h1;
      end
      if (run_in && !run_d) begin
        if (seg_cnt_out < 4'h8) begin
          seg_log_out[2*seg_cnt_out[2:0] +: 2] <= {dir_in, speed_high_in};
        end
        seg_cnt_out <= seg_cnt_out + 4'h1;
        if (!zv_d) begin
          viol_out <= viol_out + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking bench for the homing sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
  // ==========================================================================
  // Signals
  localparam int LIMIT = 40000;
  logic        clk_sys_in = 1'b0;
  logic        rstn_in;
  logic        start_in;
  logic [5:0]  mode_in;
  logic        home_switch, plim, nlim, zvel;
  logic [31:0] pos;
  logic        run_out, dir_out, speed_high_out, stop_out;
  logic        busy_out, done_out, alarm_out, home_valid_out;
  logic [31:0] home_pos_out;
  logic        load, pl_g, nl_g;
  logic [31:0] load_pos;
  logic [3:0]  decel, seg_cnt;
  logic [15:0] seg_log;
  logic [7:0]  viol;
  int          n_mismatch = 0;
  int          checked = 0;
  int          cycles = 0;

  always #25 clk_sys_in = ~clk_sys_in;

  hseq_top dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .start_in(start_in), .mode_in(mode_in), .home_switch_in(home_switch),
    .positive_limit_in(plim), .negative_limit_in(nlim),
    .zero_vel_in(zvel), .pos_in(pos), .run_out(run_out),
    .dir_out(dir_out), .speed_high_out(speed_high_out),
    .stop_out(stop_out), .busy_out(busy_out), .done_out(done_out),
    .alarm_out(alarm_out), .home_valid_out(home_valid_out),
    .home_pos_out(home_pos_out));

  hseq_axis axis (.clk_sys_in(clk_sys_in), .load_in(load),
    .load_pos_in(load_pos), .decel_in(decel), .pl_glitch_in(pl_g),
    .nl_glitch_in(nl_g), .run_in(run_out), .dir_in(dir_out),
    .speed_high_in(speed_high_out), .home_switch_out(home_switch),
    .positive_limit_out(plim), .negative_limit_out(nlim),
    .zero_vel_out(zvel), .pos_out(pos), .seg_cnt_out(seg_cnt),
    .seg_log_out(seg_log), .viol_out(viol));

  // ==========================================================================
  // Closing and hang guard
  task automatic report_and_stop;
    if (n_mismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // One homing run; lo below zero means an abort is expected.
  // Glitch 1 pulses the negative limit, 2 the positive one, once both are off
  task automatic run_case(input logic [5:0] mode, input int start_pos,
    input logic [3:0] dcl, input int glitch, input logic [3:0] gseg,
    input logic [15:0] exp_log, input logic [3:0] exp_n, input int lo,
    input int hi);
    int   k;
    logic hit;
    logic fired;
    k = 0;
    hit = 1'b0;
    fired = 1'b0;
    @(posedge clk_sys_in);
    load <= 1'b1;
    load_pos <= start_pos[31:0];
    decel <= dcl;
    @(posedge clk_sys_in);
    load <= 1'b0;
    // Switch level must settle before start picks the branch
    repeat (3) @(posedge clk_sys_in);
    start_in <= 1'b1;
    mode_in <= mode;
    @(posedge clk_sys_in);
    start_in <= 1'b0;
    do begin
      @(posedge clk_sys_in);
      pl_g <= hit & (glitch == 2);
      nl_g <= hit & (glitch == 1);
      #1;
      if (k == 0) `CHK(home_valid_out, 1'b0)
      if (k == 0) `CHK(busy_out, exp_n != 4'h0)
      hit = glitch != 0 && !fired && seg_cnt == gseg && run_out === 1'b1
            && plim === 1'b0 && nlim === 1'b0;
      fired = fired | hit;
      k++;
    end while (done_out !== 1'b1 && alarm_out !== 1'b1 && k < 4000);
    `CHK(seg_cnt, exp_n)
    `CHK(seg_log, exp_log)
    `CHK(viol, 8'h00)
    `CHK(alarm_out, lo < 0)
    if (lo < 0) begin
      `CHK({stop_out, run_out, done_out, busy_out}, 4'b1000)
    end else begin
      `CHK({done_out, home_valid_out, stop_out, busy_out}, 4'b1100)
      `CHK(home_pos_out, pos)
      `CHK(int'(home_pos_out) >= lo && int'(home_pos_out) <= hi, 1'b1)
    end
  endtask

  // ==========================================================================
  // Scenarios
  task automatic s_m24_pos;
    run_case(6'h18, 800, 4'h0, 0, 4'h0, 16'h0027, 4'h3, 400, 403);
  endtask
  task automatic s_m24_neg;
    run_case(6'h18, 200, 4'h6, 0, 4'h0, 16'h0027, 4'h3, 400, 403);
  endtask
  task automatic s_m24_act;
    run_case(6'h18, 500, 4'h0, 0, 4'h0, 16'h0009, 4'h2, 400, 403);
  endtask
  task automatic s_m25_pos;
    run_case(6'h19, 800, 4'h6, 0, 4'h0, 16'h0037, 4'h4, 597, 600);
  endtask
  task automatic s_m25_neg;
    run_case(6'h19, 200, 4'h0, 0, 4'h0, 16'h0003, 4'h2, 597, 600);
  endtask
  task automatic s_m25_act;
    run_case(6'h19, 500, 4'h6, 0, 4'h0, 16'h0003, 4'h2, 597, 600);
  endtask
  task automatic s_m26_pos;
    run_case(6'h1A, 800, 4'h0, 0, 4'h0, 16'h0027, 4'h3, 601, 604);
  endtask
  task automatic s_m26_neg;
    run_case(6'h1A, 200, 4'h6, 0, 4'h0, 16'h0027, 4'h3, 601, 604);
  endtask
  task automatic s_m26_act;
    run_case(6'h1A, 500, 4'h0, 0, 4'h0, 16'h0027, 4'h3, 601, 604);
  endtask
  task automatic s_m27_pos;
    run_case(6'h1B, 800, 4'h6, 0, 4'h0, 16'h0009, 4'h2, 601, 604);
  endtask
  task automatic s_m27_neg;
    run_case(6'h1B, 200, 4'h0, 0, 4'h0, 16'h009D, 4'h4, 601, 604);
  endtask
  task automatic s_m27_act;
    run_case(6'h1B, 500, 4'h6, 0, 4'h0, 16'h0027, 4'h3, 601, 604);
  endtask
  task automatic s_second_pl;
    run_case(6'h18, 800, 4'h0, 2, 4'h2, 16'h0007, 4'h2, -1, 0);
  endtask
  task automatic s_neg_lim_m25;
    run_case(6'h19, 500, 4'h6, 1, 4'h1, 16'h0003, 4'h1, -1, 0);
  endtask
  task automatic s_pos_lim_m27;
    run_case(6'h1B, 200, 4'h0, 2, 4'h1, 16'h0001, 4'h1, -1, 0);
  endtask
  task automatic s_second_nl;
    run_case(6'h1B, 200, 4'h6, 1, 4'h2, 16'h000D, 4'h2, -1, 0);
  endtask
  task automatic s_bad_mode;
    run_case(6'h1C, 500, 4'h0, 0, 4'h0, 16'h0000, 4'h0, -1, 0);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rstn_in = 1'b0;
    start_in = 1'b0;
    mode_in = 6'h18;
    load = 1'b1;
    load_pos = 32'h000001F4;
    decel = 4'h0;
    pl_g = 1'b0;
    nl_g = 1'b0;
    repeat (5) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(posedge clk_sys_in);
    s_m24_pos();
    s_m24_neg();
    s_m24_act();
    s_m25_pos();
    s_m25_neg();
    s_m25_act();
    s_m26_pos();
    s_m26_neg();
    s_m26_act();
    s_m27_pos();
    s_m27_neg();
    s_m27_act();
    s_second_pl();
    s_neg_lim_m25();
    s_pos_lim_m27();
    s_second_nl();
    s_bad_mode();
    s_m24_act();
    report_and_stop();
  end
endmodule
`default_nettype wire
